// ---- common/cpms_pkg.sv ----
// Shared constants and types of the card power-up and mode-select block
package cpms_pkg;
   localparam int         CLK_MHZ        = 100;
   localparam int         RAMP_US        = 1000;
   localparam int         RAMP_CYC       = RAMP_US * CLK_MHZ;
   localparam int         RAMP_W         = 17;
   localparam int         CYC_W          = 6;
   localparam logic [5:0] REFRESH_PERIOD = 6'h32;
   localparam logic [5:0] CYC_RESET      = 6'h00;
   localparam logic [5:0] CMD_GO_IDLE    = 6'h00;
   localparam logic [5:0] ACMD_SET_WIDTH = 6'h06;
   localparam logic [5:0] ACMD_OP_COND   = 6'h29;
   localparam logic [5:0] ACMD_CD_PULLUP = 6'h2A;
   localparam logic [1:0] WIDTH_4BIT     = 2'h2;
   localparam logic       PULLUP_RESET   = 1'b1;

   typedef struct packed {
      logic [5:0] idx;
      logic       app;
      logic [1:0] arg;
      logic       cs_low;
   } cpms_cmd_t;

   typedef struct packed {
      logic wide4;
      logic spi;
      logic irq_drv;
      logic rw_drv;
   } cpms_pad_t;

   typedef enum logic [2:0] {
      ST_OFF, ST_RAMP, ST_CHECK, ST_IDLE, ST_INIT, ST_READY
   } cpms_state_t;
endpackage

// ---- logic/cpms_level_sync.sv ----
// Two-flop synchroniser for quasi-static levels
`timescale 1ns/100ps
module cpms_level_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   if (W < 1) begin : g_bad_width
      $error("cpms_level_sync: W must be at least 1");
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ---- logic/cpms_pulse_sync.sv ----
// Toggle crossing of a one-cycle event between two clocks
`timescale 1ns/100ps
module cpms_pulse_sync (
   input  wire logic src_clk,
   input  wire logic src_rst_b,
   input  wire logic src_pulse,
   input  wire logic dst_clk,
   input  wire logic dst_rst_b,
   output logic      dst_pulse
);
   logic src_tgl;
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge src_clk) begin
      if (!src_rst_b) src_tgl <= 1'b0;
      else if (src_pulse) src_tgl <= ~src_tgl;
   end

   always_ff @(posedge dst_clk) begin
      if (!dst_rst_b) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= src_tgl;
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign dst_pulse = s2 ^ s3;
endmodule

// ---- logic/cpms_top.sv ----
// Card power-up sequencing, brown-out reset, mode select and pad control
// Functional notes
// [R01] Host waits 1 ms after supply reaches 2.7 V before talking.
// [R02] Host gives 74 bus clocks before the first command.
// [R03] Host sends reset, interface condition, then repeats op-condition until ready.
// [R04] Below 2.6 V no new flash access; running program may finish.
// [R05] After power loss, verify and refresh last written data at init.
// [R06] Supply dip below 2.6 V resets the card; host reinitialises fully.
// [R07] Data lines one to three stay inputs until bus width command.
// [R08] Host keeps its data line one to three drivers as inputs when idle.
// [R09] Card detect pull-up on data line three is enabled at power up.
// [R10] Host selects SD mode with line three high, SPI mode with it low.
// [R11] Host sees card presence by line three pulled high.
// [R12] Pull-up command removes the card detect pull-up.
// [R13] Count power-ons; every 50th scans and refreshes the whole array.
// [R14] SDIO: data line one signals interrupt when no transfer runs.
// [R15] SDIO: data line two may carry read wait.
// [R16] Reset command with chip select low in idle enters SPI, answers R1.
// [R17] SPI mode holds until power is cycled.
// [R18] Bus starts one bit wide; four bits only after initialisation.
// [R19] SPI chip select is active low; commands ignored while it is high.
`timescale 1ns/100ps
module cpms_top
   import cpms_pkg::*;
#(
   parameter int RAMP_CYCLES = cpms_pkg::RAMP_CYC
) (
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   input  wire logic               link_clk,
   input  wire logic               supply_ok,
   input  wire logic               supply_low,
   input  wire logic               cmd_strobe,
   input  wire cpms_pkg::cpms_cmd_t cmd_in,
   input  wire logic               xfer_active,
   input  wire logic               xfer_out,
   input  wire logic [3:1]         data_tx,
   output logic      [3:1]         dat_out,
   output logic      [3:1]         dat_oe_b,
   input  wire logic               sdio_en,
   input  wire logic               sdio_irq,
   input  wire logic               read_wait,
   input  wire logic               flash_req,
   output logic                    flash_grant,
   input  wire logic               nv_dirty,
   input  wire logic [5:0]         nv_cycles_in,
   output logic      [5:0]         nv_cycles_out,
   output logic                    nv_cycles_we,
   output logic                    verify_req,
   input  wire logic               verify_done,
   output logic                    scan_req,
   input  wire logic               scan_done,
   output logic                    pullup_en,
   output logic                    card_ready,
   output logic                    spi_mode,
   output logic                    spi_r1_req
);
   import cpms_pkg::*;

   if (RAMP_CYCLES < 1 || RAMP_CYCLES >= (1 << RAMP_W)) begin : g_bad_ramp
      $error("cpms_top: RAMP_CYCLES out of range");
   end

   // ---------------- Link domain ----------------
   logic       link_rst_b;
   logic       cmd_take;
   cpms_cmd_t  cmd_hold;
   cpms_pad_t  pad_l;
   cpms_pad_t  pad_c;
   logic [3:1] next_drv;

   cpms_level_sync #(.W(1)) u_link_rst (
      .clk   (link_clk),
      .rst_b (1'b1),
      .d     (rst_b),
      .q     (link_rst_b)
   );

   cpms_level_sync #(.W(4)) u_pad_sync (
      .clk   (link_clk),
      .rst_b (link_rst_b),
      .d     (pad_c),
      .q     (pad_l)
   );

   // Chip select is the line-three pad, sampled with the command
   assign cmd_take = cmd_strobe && !(pad_l.spi && !cmd_in.cs_low); // R19

   always_ff @(posedge link_clk) begin
      if (!link_rst_b) cmd_hold <= '0;
      else if (cmd_take) cmd_hold <= cmd_in;
   end

   always_comb begin
      next_drv    = 3'h0;
      next_drv[1] = (pad_l.wide4 && xfer_out)
                    || (pad_l.irq_drv && !xfer_active);        // R14
      next_drv[2] = (pad_l.wide4 && xfer_out)
                    || (pad_l.rw_drv && !xfer_active);         // R15
      next_drv[3] = pad_l.wide4 && xfer_out;                   // R07
      if (pad_l.spi) next_drv = 3'h0;
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_b) begin
         dat_oe_b <= 3'h7;
         dat_out  <= 3'h7;
      end else begin
         dat_oe_b <= ~next_drv;                                // R07
         dat_out[1] <= pad_l.wide4 && xfer_out ? data_tx[1] : 1'b0;
         dat_out[2] <= pad_l.wide4 && xfer_out ? data_tx[2] : 1'b0;
         dat_out[3] <= data_tx[3];
      end
   end

   // ---------------- Core domain ----------------
   logic              evt;
   logic              ok_s;
   logic              low_s;
   cpms_state_t       state;
   logic [RAMP_W-1:0] ramp_cnt;
   logic              ramp_end;
   logic              wide4;
   logic              is_app;

   cpms_pulse_sync u_cmd_evt (
      .src_clk   (link_clk),
      .src_rst_b (link_rst_b),
      .src_pulse (cmd_take),
      .dst_clk   (core_clk),
      .dst_rst_b (rst_b),
      .dst_pulse (evt)
   );

   cpms_level_sync #(.W(2)) u_supply_sync (
      .clk   (core_clk),
      .rst_b (rst_b),
      .d     ({supply_ok, supply_low}),
      .q     ({ok_s, low_s})
   );

   assign ramp_end = (state == ST_RAMP) && (ramp_cnt == RAMP_W'(RAMP_CYCLES - 1));
   assign is_app   = evt && cmd_hold.app && (state == ST_READY);

   // Power sequence; a supply dip acts as a full card reset
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state    <= ST_OFF;
         ramp_cnt <= '0;
      end else if (low_s) begin
         state    <= ST_OFF;                                   // R06
         ramp_cnt <= '0;
      end else begin
         case (state)
            ST_OFF: begin
               if (ok_s) state <= ST_RAMP;
            end
            ST_RAMP: begin
               ramp_cnt <= ramp_cnt + 1'b1;
               if (ramp_end) state <= ST_CHECK;
            end
            ST_CHECK: begin
               if (!verify_req && !scan_req) state <= ST_IDLE;
            end
            ST_IDLE, ST_INIT, ST_READY: begin
               if (evt && !cmd_hold.app && cmd_hold.idx == CMD_GO_IDLE)
                  state <= ST_INIT;
               else if (evt && cmd_hold.app && cmd_hold.idx == ACMD_OP_COND
                        && state == ST_INIT)
                  state <= ST_READY;                           // R03
            end
            default: state <= ST_OFF;
         endcase
      end
   end

   // Mode latch: SPI is left only by reset or a supply dip
   always_ff @(posedge core_clk) begin
      if (!rst_b || low_s) begin
         spi_mode   <= 1'b0;
         spi_r1_req <= 1'b0;
      end else begin
         spi_r1_req <= 1'b0;
         if (evt && !cmd_hold.app && cmd_hold.idx == CMD_GO_IDLE
             && state == ST_IDLE && cmd_hold.cs_low) begin
            spi_mode   <= 1'b1;                                // R16
            spi_r1_req <= 1'b1;
         end else if (spi_mode && evt) begin
            spi_r1_req <= 1'b0;                                // R17
         end
      end
   end

   // Bus width and card detect pull-up
   always_ff @(posedge core_clk) begin
      if (!rst_b || low_s || state == ST_OFF) begin
         wide4     <= 1'b0;
         pullup_en <= PULLUP_RESET;                            // R09
      end else if (evt && !cmd_hold.app && cmd_hold.idx == CMD_GO_IDLE) begin
         wide4 <= 1'b0;
      end else if (is_app && cmd_hold.idx == ACMD_SET_WIDTH && !spi_mode) begin
         wide4 <= (cmd_hold.arg == WIDTH_4BIT);                // R18
      end else if (is_app && cmd_hold.idx == ACMD_CD_PULLUP) begin
         pullup_en <= cmd_hold.arg[0];                         // R12
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         card_ready <= 1'b0;
         pad_c      <= '0;
      end else begin
         card_ready <= (state == ST_READY) && !low_s;
         pad_c.wide4   <= wide4;
         pad_c.spi     <= spi_mode;
         pad_c.irq_drv <= sdio_en && sdio_irq;
         pad_c.rw_drv  <= sdio_en && read_wait;
      end
   end

   // Power-on count and maintenance requests
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         nv_cycles_out <= CYC_RESET;
         nv_cycles_we  <= 1'b0;
      end else begin
         nv_cycles_we <= ramp_end && !low_s;
         if (ramp_end && !low_s)
            nv_cycles_out <= (nv_cycles_in == REFRESH_PERIOD - 1'b1)
                             ? CYC_RESET : nv_cycles_in + 1'b1; // R13
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b || low_s) begin
         verify_req <= 1'b0;
         scan_req   <= 1'b0;
      end else begin
         if (ramp_end && nv_dirty) verify_req <= 1'b1;        // R05
         else if (verify_done) verify_req <= 1'b0;
         if (ramp_end && nv_cycles_in == REFRESH_PERIOD - 1'b1)
            scan_req <= 1'b1;                                  // R13
         else if (scan_done) scan_req <= 1'b0;
      end
   end

   // New flash accesses stop as soon as the synchronised supply dip arrives; a running
   // program is not touched here so it may finish
   assign flash_grant = flash_req && !low_s && state != ST_OFF; // R04

   // ---------------- Assertions ----------------
   grant_block_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
      low_s |-> !flash_grant) else $error("flash grant during brown-out");

   brown_reset_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R06
      low_s |=> state == ST_OFF && !spi_mode && pullup_en)
      else $error("supply dip did not reset");

   spi_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R17
      spi_mode && !low_s |=> spi_mode) else $error("left SPI mode");

   spi_entry_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R16
      evt && !low_s && !cmd_hold.app && cmd_hold.idx == CMD_GO_IDLE
      && state == ST_IDLE && cmd_hold.cs_low |=> spi_mode && spi_r1_req)
      else $error("SPI entry missed");

   sd_silent_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R16
      evt && !low_s && state == ST_IDLE && !spi_mode && !cmd_hold.cs_low
      |=> !spi_r1_req && !spi_mode) else $error("SD mode answered reset");

   wide_late_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R18
      $rose(wide4) |-> $past(state) == ST_READY && !spi_mode)
      else $error("bus widened before init");

   pullup_power_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R09
      state == ST_RAMP |-> pullup_en) else $error("pull-up off at power up");

   pullup_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R12
      is_app && !low_s && cmd_hold.idx == ACMD_CD_PULLUP |=> pullup_en == $past(cmd_hold.arg[0]))
      else $error("pull-up command ignored");

   scan_period_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
      ramp_end && !low_s && nv_cycles_in == REFRESH_PERIOD - 1'b1
      |=> scan_req && nv_cycles_we && nv_cycles_out == CYC_RESET)
      else $error("fiftieth power-on scan missed");

   verify_loss_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R05
      ramp_end && !low_s && nv_dirty |=> verify_req ##1 state == ST_CHECK)
      else $error("power-loss verify missed");

   narrow_bus_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R07
      !pad_l.wide4 && !pad_l.spi |=> dat_oe_b[3]) else $error("line three driven early");

   irq_line_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R14
      pad_l.irq_drv && !pad_l.spi && !xfer_active && !xfer_out
      |=> !dat_oe_b[1] && !dat_out[1]) else $error("interrupt line not driven low");

   rw_line_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R15
      pad_l.rw_drv && !pad_l.spi && !xfer_active && !xfer_out
      |=> !dat_oe_b[2] && !dat_out[2]) else $error("read wait line not driven low");

   cs_ignore_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R19
      pad_l.spi && !cmd_in.cs_low && cmd_strobe |=> $stable(cmd_hold))
      else $error("command taken with chip select high");
endmodule

// ---- bench/cpms_host_model.sv ----
// Host model: bus clock and decoded command strobes toward the card
`timescale 1ns/100ps
module cpms_host_model
   import cpms_pkg::*;
(
   output logic                link_clk,
   output logic                cmd_strobe,
   output cpms_pkg::cpms_cmd_t cmd_in,
   output logic [3:1]          host_oe_b
);
   import cpms_pkg::*;
   int clk_cnt;

   initial begin
      link_clk   = 1'b0;
      cmd_strobe = 1'b0;
      cmd_in     = '0;
      // Host never drives data lines one to three in this bench
      host_oe_b  = 3'h7;
      clk_cnt    = 0;
      #3;
      forever #7.5 link_clk = ~link_clk;
   end

   always @(posedge link_clk) clk_cnt++;

   // One command, spaced well beyond the minimum strobe distance
   task automatic send(input logic [5:0] idx, input logic app, input logic [1:0] arg,
                       input logic cs_low);
      while (clk_cnt < 74) @(negedge link_clk);
      @(negedge link_clk);
      cmd_in     = '{idx, app, arg, cs_low};
      cmd_strobe = 1'b1;
      @(negedge link_clk);
      cmd_strobe = 1'b0;
      // Released lines must not keep showing the last value
      cmd_in     = ~cmd_in;
      repeat (8) @(negedge link_clk);
   endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench of the card power-up and mode-select block
`timescale 1ns/100ps
module testbench;
   import cpms_pkg::*;
   logic       core_clk, rst_b, link_clk, supply_ok, supply_low, cmd_strobe;
   cpms_cmd_t  cmd_in;
   logic       xfer_active, xfer_out, sdio_en, sdio_irq, read_wait, flash_req;
   logic       flash_grant, nv_dirty, nv_cycles_we, verify_req, verify_done;
   logic       scan_req, scan_done, pullup_en, card_ready, spi_mode, spi_r1_req;
   logic [3:1] data_tx, dat_out, dat_oe_b, host_oe_b;
   logic [5:0] nv_cycles_in, nv_cycles_out;
   int         err_total, num_checks, cyc, r1_cnt;

   cpms_host_model host (.link_clk(link_clk), .cmd_strobe(cmd_strobe), .cmd_in(cmd_in),
                         .host_oe_b(host_oe_b));

   cpms_top #(.RAMP_CYCLES(20)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk), .supply_ok(supply_ok),
      .supply_low(supply_low), .cmd_strobe(cmd_strobe), .cmd_in(cmd_in),
      .xfer_active(xfer_active), .xfer_out(xfer_out), .data_tx(data_tx),
      .dat_out(dat_out), .dat_oe_b(dat_oe_b), .sdio_en(sdio_en), .sdio_irq(sdio_irq),
      .read_wait(read_wait), .flash_req(flash_req), .flash_grant(flash_grant),
      .nv_dirty(nv_dirty), .nv_cycles_in(nv_cycles_in), .nv_cycles_out(nv_cycles_out),
      .nv_cycles_we(nv_cycles_we), .verify_req(verify_req), .verify_done(verify_done),
      .scan_req(scan_req), .scan_done(scan_done), .pullup_en(pullup_en),
      .card_ready(card_ready), .spi_mode(spi_mode), .spi_r1_req(spi_r1_req)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(negedge core_clk) begin
      if (spi_r1_req === 1'b1) r1_cnt++;
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         end_of_test();
      end
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic link_wait(input int n);
      repeat (n) @(negedge link_clk);
      @(negedge core_clk);
   endtask

   task automatic power_up(input logic [5:0] cnt, input logic dirty);
      int n;
      n            = 0;
      nv_cycles_in = cnt;
      nv_dirty     = dirty;
      while (nv_cycles_we !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      chk(nv_cycles_out, (cnt == 6'h31) ? 6'h00 : cnt + 6'h01);
      @(negedge core_clk);
      chk(scan_req, cnt == 6'h31);
      chk(verify_req, dirty);
      chk({pullup_en, dat_oe_b}, 4'hF);
      verify_done = 1'b1;
      scan_done   = 1'b1;
      repeat (4) @(negedge core_clk);
      chk({verify_req, scan_req}, 2'h0);
      verify_done = 1'b0;
      scan_done   = 1'b0;
      $display("test power_up done");
   endtask

   task automatic sd_init;
      host.send(CMD_GO_IDLE, 1'b0, 2'h0, 1'b0);
      host.send(6'h08, 1'b0, 2'h0, 1'b0);
      chk(card_ready, 1'b0);
      host.send(ACMD_OP_COND, 1'b1, 2'h0, 1'b0);
      chk({spi_mode, card_ready, r1_cnt[7:0]}, 10'h100);
      xfer_active = 1'b1;
      xfer_out    = 1'b1;
      link_wait(6);
      chk(dat_oe_b, 3'h7);
      host.send(ACMD_SET_WIDTH, 1'b1, WIDTH_4BIT, 1'b0);
      chk({dat_oe_b, dat_out}, 6'h02);
      chk({host_oe_b, dat_oe_b}, 6'h38);
      xfer_active = 1'b0;
      xfer_out    = 1'b0;
      sdio_en     = 1'b1;
      sdio_irq    = 1'b1;
      read_wait   = 1'b1;
      link_wait(6);
      chk({dat_oe_b[2:1], dat_out[2:1]}, 4'h0);
      sdio_en = 1'b0;
      host.send(ACMD_CD_PULLUP, 1'b1, 2'h0, 1'b0);
      chk(pullup_en, 1'b0);
      xfer_out = 1'b1;
      host.send(ACMD_SET_WIDTH, 1'b1, 2'h0, 1'b0);
      chk(dat_oe_b, 3'h7);
      xfer_out = 1'b0;
      $display("test sd_init done");
   endtask

   task automatic brownout;
      flash_req = 1'b1;
      @(negedge core_clk);
      chk(flash_grant, 1'b1);
      supply_low = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(flash_grant, 1'b0);
      link_wait(6);
      chk({spi_mode, card_ready, pullup_en, dat_oe_b}, 6'h0F);
      flash_req  = 1'b0;
      supply_low = 1'b0;
      power_up(6'h31, 1'b1);
      $display("test brownout done");
   endtask

   task automatic spi_entry;
      host.send(CMD_GO_IDLE, 1'b0, 2'h0, 1'b1);
      chk({spi_mode, r1_cnt[7:0]}, 9'h101);
      host.send(ACMD_OP_COND, 1'b1, 2'h0, 1'b1);
      chk(card_ready, 1'b1);
      host.send(CMD_GO_IDLE, 1'b0, 2'h0, 1'b0);
      chk({spi_mode, card_ready}, 2'h3);
      host.send(CMD_GO_IDLE, 1'b0, 2'h0, 1'b1);
      chk({spi_mode, card_ready}, 2'h2);
      host.send(ACMD_OP_COND, 1'b1, 2'h0, 1'b1);
      xfer_out = 1'b1;
      host.send(ACMD_SET_WIDTH, 1'b1, WIDTH_4BIT, 1'b1);
      chk(dat_oe_b, 3'h7);
      xfer_out = 1'b0;
      host.send(ACMD_CD_PULLUP, 1'b1, 2'h0, 1'b1);
      chk(pullup_en, 1'b0);
      host.send(ACMD_CD_PULLUP, 1'b1, 2'h1, 1'b1);
      chk(pullup_en, 1'b1);
      $display("test spi_entry done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      {err_total, num_checks, cyc, r1_cnt} = '0;
      {rst_b, supply_low, xfer_active, xfer_out, sdio_en, sdio_irq} = '0;
      {read_wait, flash_req, nv_dirty, verify_done, scan_done} = '0;
      supply_ok    = 1'b1;
      data_tx      = 3'h2;
      nv_cycles_in = 6'h05;
      repeat (8) @(negedge core_clk);
      rst_b = 1'b1;
      power_up(6'h05, 1'b0);
      sd_init();
      brownout();
      spi_entry();
      end_of_test();
   end
endmodule
